// >>> uhp_hub_connect.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "uhp_cfg.svh"
// Overview of operation
// - One upstream, four downstream ports
// - Engine handles framing, handshakes, address match
// - Address zero accepted before assignment
// - Both lines low means no connect
// - Low-speed line sets connect, raises event
// - Full-speed line sets connect, clears speed
// - Connect after 2.5 us of J or K (SE1 does not connect)
// - Disconnect after 2.0 to 2.5 us SE0
// - Connect bits 0..3 one per port
// - Connect register cleared by any reset
// - Connect upper nibble reads zero
// - Speed bits: as written, cleared to zero by a full-speed connect
// - End-of-packet driven at EOF1
// - Forced ports raise no event
// - Speed register cleared by any reset
module uhp_hub_connect
  (
   input  wire logic         CLK,
   input  wire logic         RESETN,
   input  wire logic         BUS_RESET,
   input  wire logic         EOF1_POINT,
   input  wire logic [3:0]   DP_IN,
   input  wire logic [3:0]   DM_IN,
   input  wire logic [6:0]   TOKEN_ADDR,
   input  wire logic [3:0]   ADDR,
   input  wire logic [7:0]   WDATA,
   input  wire logic         WR,
   input  wire logic         RD,
   output      logic [7:0]   RDATA,
   output      logic         HUB_EVENT,
   output      logic         ADDR_MATCH,
   output      logic         EOP_DRIVE
   );
   import uhp_pkg::*;
   logic [3:0] dp_s1_r, dp_s2_r, dp_s3_r;
   logic [3:0] dm_s1_r, dm_s2_r, dm_s3_r;
   logic [3:0] dp_q_r, dm_q_r;
   logic [3:0] speed_r;
   logic [3:0] force_r;
   logic [6:0] dev_addr_r;
   logic       event_r;
   uhp_filt_if fi ();

   function automatic logic hit(input logic [3:0] a, input logic [3:0] k);
      hit = (a == k);
   endfunction : hit

   // Three-stage sampling; accept once stages two and three agree
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         dp_s1_r <= '0; dp_s2_r <= '0; dp_s3_r <= '0; dp_q_r <= '0;
         dm_s1_r <= '0; dm_s2_r <= '0; dm_s3_r <= '0; dm_q_r <= '0;
      end
      else
      begin
         dp_s1_r <= DP_IN;
         dp_s2_r <= dp_s1_r;
         dp_s3_r <= dp_s2_r;
         dm_s1_r <= DM_IN;
         dm_s2_r <= dm_s1_r;
         dm_s3_r <= dm_s2_r;
         for (int i = 0; i < `UHP_PORTS; i++)
         begin
            if (dp_s2_r[i] == dp_s3_r[i])
               dp_q_r[i] <= dp_s3_r[i];
            if (dm_s2_r[i] == dm_s3_r[i])
               dm_q_r[i] <= dm_s3_r[i];
         end
      end
   end

   logic [3:0] conn_w, low_w, chg_w;
   genvar g;
   generate
      for (g = 0; g < `UHP_PORTS; g++)
      begin : g_port
         uhp_port_filter u_filt
           (
            .clk     (CLK),
            .resetn  (RESETN),
            .bus_rst (BUS_RESET),
            .dp_sync (dp_q_r[g]),
            .dm_sync (dm_q_r[g]),
            .conn_o  (conn_w[g]),
            .low_o   (low_w[g]),
            .chg_o   (chg_w[g])
            );
      end
   endgenerate
   assign fi.conn = conn_w;
   assign fi.low  = low_w;
   assign fi.chg  = chg_w;

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         speed_r <= '0;
      else if (BUS_RESET)
         speed_r <= '0;
      else
         for (int i = 0; i < `UHP_PORTS; i++)
         begin
            if (fi.chg[i] && fi.conn[i] && !fi.low[i])
               speed_r[i] <= 1'b0;
            else if (WR && hit(ADDR, `UHP_ADDR_SPEED))
               speed_r[i] <= WDATA[i];
         end
   end

   // Port forcing mask, cleared by chip reset only
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         force_r <= '0;
      else if (WR && hit(ADDR, `UHP_ADDR_FORCE))
         force_r <= WDATA[3:0];
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         dev_addr_r <= `UHP_DEFAULT_ADDR;
      else if (BUS_RESET)
         dev_addr_r <= `UHP_DEFAULT_ADDR;
      else if (WR && hit(ADDR, `UHP_ADDR_DEVADDR))
         dev_addr_r <= WDATA[6:0];
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         ADDR_MATCH <= 1'b0;
      else
         ADDR_MATCH <= (TOKEN_ADDR == dev_addr_r);
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         EOP_DRIVE <= 1'b0;
      else
         EOP_DRIVE <= EOF1_POINT;
   end

   logic ev_set;
   assign ev_set = |(fi.chg & ~force_r);
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         event_r <= 1'b0;
      else if (BUS_RESET)
         event_r <= 1'b0;
      else if (ev_set)
         event_r <= 1'b1;
      else if (WR && hit(ADDR, `UHP_ADDR_STATUS) && WDATA[0])
         event_r <= 1'b0;
   end
   assign HUB_EVENT = event_r;

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
         RDATA <= `UHP_REG_RESET;
      else if (RD)
         unique case (ADDR)
            `UHP_ADDR_CONNECT:  RDATA <= {4'h0, fi.conn};
            `UHP_ADDR_SPEED:    RDATA <= {4'h0, speed_r};
            `UHP_ADDR_FORCE:    RDATA <= {4'h0, force_r};
            `UHP_ADDR_DEVADDR:  RDATA <= {1'b0, dev_addr_r};
            `UHP_ADDR_STATUS:   RDATA <= {7'h00, event_r};
            `UHP_ADDR_LSDETECT: RDATA <= {4'h0, fi.low};
            default:            RDATA <= `UHP_REG_RESET;
         endcase
      else
         RDATA <= `UHP_REG_RESET;
   end

   property p_conn_rise;
      @(posedge CLK) disable iff (!RESETN)
      $rose(fi.conn[0]) |-> $past(fi.chg[0]) == 1'b0 && fi.chg[0];
   endproperty
   a_conn_rise: assert property (p_conn_rise)
      else $error("connect rose without change pulse");

   property p_event_set;
      @(posedge CLK) disable iff (!RESETN)
      (ev_set && !BUS_RESET) |=> HUB_EVENT;
   endproperty
   a_event_set: assert property (p_event_set)
      else $error("event not raised");

   property p_forced;
      @(posedge CLK) disable iff (!RESETN)
      (!HUB_EVENT && fi.chg != 4'h0 && (fi.chg & ~force_r) == 4'h0)
         |=> !HUB_EVENT;
   endproperty
   a_forced: assert property (p_forced)
      else $error("forced port raised event");

   property p_rst_clear;
      @(posedge CLK) disable iff (!RESETN)
      BUS_RESET |=> (fi.conn == 4'h0) && (speed_r == 4'h0);
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("bus reset did not clear");

   property p_upper;
      @(posedge CLK) disable iff (!RESETN)
      $past(RD) && $past(ADDR) == `UHP_ADDR_CONNECT |-> RDATA[7:4] == 4'h0;
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper connect bits nonzero");

   property p_fs_speed;
      @(posedge CLK) disable iff (!RESETN)
      (fi.chg[0] && fi.conn[0] && !fi.low[0] && !BUS_RESET) |=> !speed_r[0];
   endproperty
   a_fs_speed: assert property (p_fs_speed)
      else $error("full speed did not clear speed");

   property p_eop;
      @(posedge CLK) disable iff (!RESETN)
      EOF1_POINT |=> EOP_DRIVE;
   endproperty
   a_eop: assert property (p_eop)
      else $error("no eop at eof1");

   property p_addr0;
      @(posedge CLK) disable iff (!RESETN)
      (dev_addr_r == 7'h00 && TOKEN_ADDR == 7'h00) |=> ADDR_MATCH;
   endproperty
   a_addr0: assert property (p_addr0)
      else $error("address zero not accepted");

   // Port 0 line age, kept apart from the filter counters for checking
   logic [`UHP_CNT_W-1:0] live_age_r;
   logic [`UHP_CNT_W-1:0] se0_age_r;
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         live_age_r <= '0;
         se0_age_r  <= '0;
      end
      else if (dp_q_r[0] || dm_q_r[0])
      begin
         se0_age_r <= '0;
         if (live_age_r != {`UHP_CNT_W{1'b1}})
            live_age_r <= live_age_r + 1'b1;
      end
      else
      begin
         live_age_r <= '0;
         if (se0_age_r != {`UHP_CNT_W{1'b1}})
            se0_age_r <= se0_age_r + 1'b1;
      end
   end

   property p_conn_time;
      @(posedge CLK) disable iff (!RESETN)
      $rose(fi.conn[0]) |-> live_age_r >= `UHP_CNT_W'(`UHP_CONNECT_CYC);
   endproperty
   a_conn_time: assert property (p_conn_time)
      else $error("connect recorded too early");

   property p_disc_time;
      @(posedge CLK) disable iff (!RESETN)
      ($fell(fi.conn[0]) && !$past(BUS_RESET)) |->
         se0_age_r >= `UHP_CNT_W'(`UHP_DISC_CYC) &&
         se0_age_r <= `UHP_CNT_W'(`UHP_DISC_MAX_CYC);
   endproperty
   a_disc_time: assert property (p_disc_time)
      else $error("disconnect outside its window");

   property p_se0_idle;
      @(posedge CLK) disable iff (!RESETN)
      se0_age_r > `UHP_CNT_W'(`UHP_DISC_MAX_CYC) |-> !fi.conn[0];
   endproperty
   a_se0_idle: assert property (p_se0_idle)
      else $error("connected while lines low");

   property p_ls_event;
      @(posedge CLK) disable iff (!RESETN)
      (fi.chg[1] && fi.conn[1] && fi.low[1] && !force_r[1] && !BUS_RESET)
         |=> HUB_EVENT;
   endproperty
   a_ls_event: assert property (p_ls_event)
      else $error("low speed connect raised no event");

   property p_eop_quiet;
      @(posedge CLK) disable iff (!RESETN)
      !EOF1_POINT |=> !EOP_DRIVE;
   endproperty
   a_eop_quiet: assert property (p_eop_quiet)
      else $error("eop outside eof1");
endmodule : uhp_hub_connect

// >>> uhp_cfg.svh
`ifndef UHP_CFG_SVH
`define UHP_CFG_SVH
// Register indices (chosen map)
`define UHP_ADDR_CONNECT   4'h0
`define UHP_ADDR_SPEED     4'h1
`define UHP_ADDR_FORCE     4'h2
`define UHP_ADDR_DEVADDR   4'h3
`define UHP_ADDR_STATUS    4'h4
`define UHP_ADDR_LSDETECT  4'h5
`define UHP_REG_RESET      8'h00
// Timing
`define UHP_CLK_MHZ        100
`define UHP_CONNECT_NS     2500
`define UHP_DISC_MIN_NS    2000
`define UHP_CONNECT_CYC    (`UHP_CONNECT_NS * `UHP_CLK_MHZ / 1000 + 1)
`define UHP_DISC_CYC       ((`UHP_DISC_MIN_NS * `UHP_CLK_MHZ + 999) / 1000)
`define UHP_DISC_MAX_CYC   (`UHP_CONNECT_NS * `UHP_CLK_MHZ / 1000)
`define UHP_CNT_W          9
`define UHP_PORTS          4
`define UHP_DEFAULT_ADDR   7'h00
`endif

// >>> uhp_pkg.sv
package uhp_pkg;
   typedef enum logic [1:0] {
      LS_SE0,
      LS_J_FS,
      LS_K_LS,
      LS_SE1
   } uhp_line_t;
endpackage : uhp_pkg

// >>> uhp_filt_if.sv
`timescale 1ns/100ps
interface uhp_filt_if;
   logic [3:0] conn;
   logic [3:0] low;
   logic [3:0] chg;
   modport filt (output conn, output low, output chg);
   modport top  (input  conn, input  low, input  chg);
endinterface : uhp_filt_if

// >>> uhp_port_filter.sv
`timescale 1ns/100ps
`include "uhp_cfg.svh"
module uhp_port_filter
  (
   input  wire logic   clk,
   input  wire logic   resetn,
   input  wire logic   bus_rst,
   input  wire logic   dp_sync,
   input  wire logic   dm_sync,
   output      logic   conn_o,
   output      logic   low_o,
   output      logic   chg_o
   );
   import uhp_pkg::*;
   uhp_line_t               line_r;
   logic [`UHP_CNT_W-1:0]   cnt_r;
   uhp_line_t               line_now;
   assign line_now = uhp_line_t'({dm_sync, dp_sync});
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         line_r <= LS_SE0;
         cnt_r  <= '0;
      end
      else if (line_now != line_r)
      begin
         line_r <= line_now;
         cnt_r  <= '0;
      end
      // Bus reset restarts timing so a port reconnects after the full time
      else if (bus_rst)
         cnt_r  <= '0;
      else if (cnt_r != {`UHP_CNT_W{1'b1}})
         cnt_r <= cnt_r + 1'b1;
   end
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         conn_o <= 1'b0;
         low_o  <= 1'b0;
         chg_o  <= 1'b0;
      end
      else if (bus_rst)
      begin
         conn_o <= 1'b0;
         low_o  <= 1'b0;
         chg_o  <= 1'b0;
      end
      else
      begin
         chg_o <= 1'b0;
         if (!conn_o && (line_r == LS_J_FS || line_r == LS_K_LS) &&
             cnt_r == `UHP_CNT_W'(`UHP_CONNECT_CYC))
         begin
            conn_o <= 1'b1;
            low_o  <= (line_r == LS_K_LS);
            chg_o  <= 1'b1;
         end
         else if (conn_o && line_r == LS_SE0 &&
                  cnt_r == `UHP_CNT_W'(`UHP_DISC_CYC))
         begin
            conn_o <= 1'b0;
            chg_o  <= 1'b1;
         end
      end
   end
endmodule : uhp_port_filter

// >>> uhp_dev_model.sv
`timescale 1ns/100ps
module uhp_dev_model
  (
   input  wire logic [7:0] attach,
   output      logic [3:0] dp,
   output      logic [3:0] dm
   );
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         dp[i] = attach[2*i+:2] == 2'h1;
         dm[i] = attach[2*i+:2] == 2'h2;
      end
   end
endmodule : uhp_dev_model

// >>> test_usb_hub_port_connect_detect.sv
`timescale 1ns/100ps
`include "uhp_cfg.svh"
module test_usb_hub_port_connect_detect;
   logic       clk;
   logic       resetn;
   logic       bus_rst;
   logic       eof1;
   logic       wr;
   logic       rd;
   logic       rd_d;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic [6:0] tok;
   logic [6:0] a;
   logic [7:0] attach;
   logic [3:0] dp;
   logic [3:0] dm;
   logic [7:0] rdata;
   logic       ev;
   logic       match;
   logic       eop;
   logic [7:0] exp_q[$];
   int         n_mismatch;
   int         checks;

   uhp_dev_model dev_u (.attach(attach), .dp(dp), .dm(dm));
   uhp_hub_connect dut_u (.CLK(clk), .RESETN(resetn), .BUS_RESET(bus_rst),
      .EOF1_POINT(eof1), .DP_IN(dp), .DM_IN(dm), .TOKEN_ADDR(tok),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .HUB_EVENT(ev), .ADDR_MATCH(match), .EOP_DRIVE(eop));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("mismatches=%0d checks=%0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wreg(input logic [3:0] ad, input logic [7:0] d);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wreg

   task automatic rreg(input logic [3:0] ad, input logic [7:0] e);
      exp_q.push_back(e);
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask : rreg

   task automatic evchk(input logic e);
      @(negedge clk);
      chk({7'h00, ev}, {7'h00, e});
      @(posedge clk);
   endtask : evchk

   task automatic ptok(input logic [6:0] t, input logic m);
      tok <= t;
      eof1 <= 1'b1;
      @(posedge clk);
      eof1 <= 1'b0;
      @(negedge clk);
      chk({6'h00, eop, match}, {6'h00, 1'b1, m});
      @(posedge clk);
   endtask : ptok

   // Read data stand only in the cycle after the strobe
   always @(posedge clk)
      rd_d <= rd;
   always @(negedge clk)
      if (rd_d === 1'b1)
      begin
         if (exp_q.size() > 0)
            chk(rdata, exp_q.pop_front());
         else
            chk(8'hff, 8'h00);
      end

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial
   begin
      cyc(20000);
      n_mismatch++;
      test_done;
   end

   initial
   begin
      resetn = 1'b0;
      bus_rst = 1'b0;
      eof1 = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      tok = 7'h00;
      attach = 8'h00;
      a = 7'h00;
      void'($urandom(32'hd3806a7f));
      cyc(6);
      resetn <= 1'b1;
      @(posedge clk);
      rreg(`UHP_ADDR_CONNECT, 8'h00);
      rreg(`UHP_ADDR_SPEED, 8'h00);
      rreg(4'hf, 8'h00);
      ptok(7'h00, 1'b1);
      wreg(`UHP_ADDR_SPEED, 8'hff);
      rreg(`UHP_ADDR_SPEED, 8'h0f);
      attach <= 8'h01;
      cyc(270);
      rreg(`UHP_ADDR_CONNECT, 8'h01);
      rreg(`UHP_ADDR_SPEED, 8'h0e);
      evchk(1'b1);
      rreg(`UHP_ADDR_STATUS, 8'h01);
      // Firmware services and clears the event
      wreg(`UHP_ADDR_STATUS, 8'h01);
      evchk(1'b0);
      attach <= 8'h09;
      cyc(270);
      rreg(`UHP_ADDR_CONNECT, 8'h03);
      rreg(`UHP_ADDR_SPEED, 8'h0e);
      rreg(`UHP_ADDR_LSDETECT, 8'h02);
      evchk(1'b1);
      wreg(`UHP_ADDR_SPEED, 8'h02);
      rreg(`UHP_ADDR_SPEED, 8'h02);
      wreg(`UHP_ADDR_STATUS, 8'h01);
      attach <= 8'h19;
      cyc(150);
      attach <= 8'h09;
      cyc(270);
      rreg(`UHP_ADDR_CONNECT, 8'h03);
      evchk(1'b0);
      wreg(`UHP_ADDR_FORCE, 8'h08);
      rreg(`UHP_ADDR_FORCE, 8'h08);
      attach <= 8'h49;
      cyc(270);
      rreg(`UHP_ADDR_CONNECT, 8'h0b);
      evchk(1'b0);
      attach <= 8'h48;
      cyc(190);
      rreg(`UHP_ADDR_CONNECT, 8'h0b);
      cyc(60);
      rreg(`UHP_ADDR_CONNECT, 8'h0a);
      evchk(1'b1);
      wreg(`UHP_ADDR_CONNECT, 8'hf5);
      rreg(`UHP_ADDR_CONNECT, 8'h0a);
      // Firmware loads each assigned address in turn
      for (int k = 0; k < 8; k++)
      begin
         a = 7'($urandom % 126 + 2);
         wreg(`UHP_ADDR_DEVADDR, {1'b0, a});
         ptok(a, 1'b1);
         ptok(a ^ 7'h01, 1'b0);
      end
      rreg(`UHP_ADDR_DEVADDR, {1'b0, a});
      bus_rst <= 1'b1;
      cyc(2);
      bus_rst <= 1'b0;
      @(posedge clk);
      rreg(`UHP_ADDR_CONNECT, 8'h00);
      rreg(`UHP_ADDR_SPEED, 8'h00);
      evchk(1'b0);
      ptok(7'h00, 1'b1);
      cyc(270);
      rreg(`UHP_ADDR_CONNECT, 8'h0a);
      evchk(1'b1);
      test_done;
   end
endmodule : test_usb_hub_port_connect_detect
